// ---- rtl/esf_pkg.sv ----
// Shared constants for the exception source front end
package esf_pkg;
    localparam int TICK_W = 24;
    localparam int TICK_DIV = 32;
    localparam int TICK_DIV_W = 5;
    localparam logic [TICK_DIV_W-1:0] TICK_DIV_LAST = 5'h1f;
    localparam logic [TICK_W-1:0] TICK_CAL_VALUE = 24'h0009c4;
    localparam logic [TICK_W-1:0] TICK_RESET_VALUE = 24'h000000;
    localparam int SYNC_STAGES = 2;
    localparam int RST_CAUSE_W = 3;
    localparam int RST_CAUSE_PIN = 0;
    localparam int RST_CAUSE_WDT = 1;
    localparam int RST_CAUSE_SW = 2;
    localparam int NMI_CAUSE_W = 2;
    localparam int NMI_CAUSE_PIN = 0;
    localparam int NMI_CAUSE_WDT = 1;
    localparam int LEVEL_W = 2;
    localparam int LEVEL_EDGE_BIT = 1;
    localparam int LEVEL_HIGH_BIT = 0;
    localparam logic [LEVEL_W-1:0] LEVEL_LOW = 2'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_HIGH = 2'h1;
    localparam logic [LEVEL_W-1:0] LEVEL_FALL = 2'h2;
    localparam logic [LEVEL_W-1:0] LEVEL_RISE = 2'h3;
    localparam logic RST_PIN_INIT = 1'b0;
    localparam logic NMI_PIN_INIT = 1'b1;
    localparam logic IRQ_PIN_INIT = 1'b0;
endpackage : esf_pkg

// ---- rtl/esf_wake_if.sv ----
// Carrier between the router and the standby wake detector
`timescale 1ns/1ps
interface esf_wake_if #(
    parameter int N = 8
);
    logic [N-1:0] src;
    logic [N-1:0] en;
    logic [N-1:0] edge_mode;
    logic [N-1:0] high_act;
    logic [N-1:0] clr;
    logic [N-1:0] req;

    modport ctl(
        output src,
        output en,
        output edge_mode,
        output high_act,
        output clr,
        input req
    );

    modport det(
        input src,
        input en,
        input edge_mode,
        input high_act,
        input clr,
        output req
    );
endinterface : esf_wake_if

// ---- rtl/esf_wake_detect.sv ----
// Per-source standby wake detection with sticky edge capture
`timescale 1ns/1ps
module esf_wake_detect #(
    parameter int N = 8
)(
    input wire logic mclk,
    input wire logic rstn,
    esf_wake_if.det wk
);
    import esf_pkg::*;

    logic [N-1:0] prev_q;
    logic [N-1:0] req_q;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] edge_hit;
    logic [N-1:0] level_hit;

    assign rise = wk.src & ~prev_q;
    assign fall = ~wk.src & prev_q;
    // Per-bit select; each source picks its own edge direction
    assign edge_hit = wk.en & ((wk.high_act & rise) | (~wk.high_act & fall));
    assign level_hit = wk.en & ~(wk.src ^ wk.high_act);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            prev_q <= '0;
        else
            prev_q <= wk.src;
    end

    // Edge requests stay latched; a new edge beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            req_q <= '0;
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (wk.edge_mode[i])
                    req_q[i] <= edge_hit[i] | (req_q[i] & ~wk.clr[i]);
                else
                    req_q[i] <= level_hit[i];
            end
        end
    end

    assign wk.req = req_q;
endmodule : esf_wake_detect

// ---- rtl/esf_tick_timer.sv ----
// System tick down counter fed by the divided oscillator
`timescale 1ns/1ps
module esf_tick_timer (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic osc_level,
    input wire logic enable,
    input wire logic [esf_pkg::TICK_W-1:0] reload,
    output logic [esf_pkg::TICK_W-1:0] current,
    output logic zero_event
);
    import esf_pkg::*;

    logic osc_prev_q;
    logic [TICK_DIV_W-1:0] div_q;
    logic tick;
    logic enable_prev_q;
    logic [TICK_W-1:0] count_q;
    logic zero_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            osc_prev_q <= 1'b0;
        else
            osc_prev_q <= osc_level;
    end

    // One tick per thirty-two oscillator rising edges
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            div_q <= '0;
        else if (osc_level && !osc_prev_q)
            div_q <= div_q + 5'h01;
    end

    assign tick = osc_level && !osc_prev_q && (div_q == TICK_DIV_LAST);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            enable_prev_q <= 1'b0;
        else
            enable_prev_q <= enable;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            count_q <= TICK_RESET_VALUE;
        else if (enable && !enable_prev_q)
            count_q <= reload;
        else if (enable && tick)
        begin
            if (count_q == TICK_RESET_VALUE)
                count_q <= reload;
            else
                count_q <= count_q - 24'h000001;
        end
    end

    // Reload of zero never fires; the count just sits at zero
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            zero_q <= 1'b0;
        else
            zero_q <= enable && enable_prev_q && tick && (count_q == 24'h000001);
    end

    assign current = count_q;
    assign zero_event = zero_q;
endmodule : esf_tick_timer

// ---- rtl/esf_top.sv ----
// Exception source front end: reset, NMI, tick timer and interrupt routing
//
// What this block does
// - Raise reset exception when the synchronised external reset pin rises.
// - Reset sources are pin, watchdog and software; cause kept in readable flags.
// - Software reset request bit write raises a system reset exception.
// - Raise NMI when the external NMI pin falls from high to low.
// - NMI sources are pin and watchdog; cause kept in readable flags.
// - Watchdog feeds both the reset source and the NMI source inputs.
// - Enabling the tick timer loads reload value, then counts down per tick.
// - Tick counter reaching zero raises tick exception and sets a pollable flag.
// - Tick clock is the main oscillator input divided by thirty-two.
// - Calibration value reads fixed 0x9C4, ten milliseconds at 8 MHz.
// - Peripheral requests not used for wake go straight to the core.
// - Wake peripheral requests and wake pin requests pass the wake detector.
// - Pin requests not used for wake go straight to the core.
// - A set-pending bit forces a pending request for that source.
// - A pin with input disabled reads high internally, a direct request when not used for wake; otherwise it feeds the wake detector.
// - Core sees high level as request; direct peripherals drive high.
// - Wake peripherals detect rising/falling; wake pins also high/low level.
// - Each wake source has its own enable and active level field.
// - Detected wake request reaches the core as a high level.
// - Edge requests latch; level requests last only while the level holds.
// - Detected edge request stays high until cleared through the wake clear bits.
`timescale 1ns/1ps
module esf_top #(
    parameter int NP = 8,
    parameter int NX = 8
)(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic reset_pin,
    input wire logic wdt_reset_req,
    input wire logic software_reset_request,
    input wire logic [esf_pkg::RST_CAUSE_W-1:0] reset_cause_clear,
    output logic reset_exception,
    output logic [esf_pkg::RST_CAUSE_W-1:0] reset_cause_flags,
    input wire logic nmi_pin_n,
    input wire logic wdt_nmi_req,
    input wire logic [esf_pkg::NMI_CAUSE_W-1:0] nmi_cause_clear,
    output logic nmi_exception,
    output logic [esf_pkg::NMI_CAUSE_W-1:0] nmi_cause_flags,
    input wire logic main_oscillator_input,
    input wire logic tick_enable,
    input wire logic [esf_pkg::TICK_W-1:0] tick_reload,
    input wire logic tick_flag_clear,
    output logic [esf_pkg::TICK_W-1:0] tick_current,
    output logic [esf_pkg::TICK_W-1:0] tick_calibration,
    output logic tick_count_flag,
    output logic tick_exception,
    input wire logic [NP-1:0] periph_irq,
    input wire logic [NP-1:0] periph_wake_sel,
    input wire logic [NX-1:0] ext_irq_pin,
    input wire logic [NX-1:0] pin_input_enable,
    input wire logic [NX-1:0] pin_wake_sel,
    input wire logic [NP+NX-1:0] wake_source_enable,
    input wire logic [esf_pkg::LEVEL_W*(NP+NX)-1:0] wake_active_level,
    input wire logic [NP+NX-1:0] wake_request_clear,
    output logic [NP+NX-1:0] wake_request,
    input wire logic [NP+NX-1:0] set_pending,
    input wire logic [NP+NX-1:0] clear_pending,
    output logic [NP+NX-1:0] core_irq
);
    import esf_pkg::*;

    localparam int NI = NP + NX;

    function automatic logic rose(input logic prev, input logic cur);
        rose = cur & ~prev;
    endfunction : rose

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction : fell

    // Pin synchronisers; stage one is read by stage two only
    logic rst_pin_s1_q;
    logic rst_pin_s2_q;
    logic rst_pin_prev_q;
    logic nmi_pin_s1_q;
    logic nmi_pin_s2_q;
    logic nmi_pin_prev_q;
    logic osc_s1_q;
    logic osc_s2_q;
    logic [NX-1:0] pin_s1_q;
    logic [NX-1:0] pin_s2_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_pin_s1_q <= RST_PIN_INIT;
            rst_pin_s2_q <= RST_PIN_INIT;
            rst_pin_prev_q <= RST_PIN_INIT;
        end
        else
        begin
            rst_pin_s1_q <= reset_pin;
            rst_pin_s2_q <= rst_pin_s1_q;
            rst_pin_prev_q <= rst_pin_s2_q;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            nmi_pin_s1_q <= NMI_PIN_INIT;
            nmi_pin_s2_q <= NMI_PIN_INIT;
            nmi_pin_prev_q <= NMI_PIN_INIT;
        end
        else
        begin
            nmi_pin_s1_q <= nmi_pin_n;
            nmi_pin_s2_q <= nmi_pin_s1_q;
            nmi_pin_prev_q <= nmi_pin_s2_q;
        end
    end

    // Oscillator is sampled, not used as a clock; it must stay below mclk / 4
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
        end
        else
        begin
            osc_s1_q <= main_oscillator_input;
            osc_s2_q <= osc_s1_q;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s1_q <= {NX{IRQ_PIN_INIT}};
            pin_s2_q <= {NX{IRQ_PIN_INIT}};
        end
        else
        begin
            pin_s1_q <= ext_irq_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Reset sources
    logic wdt_rst_prev_q;
    logic [RST_CAUSE_W-1:0] rst_hit;
    logic [RST_CAUSE_W-1:0] rst_flags_q;
    logic rst_exc_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            wdt_rst_prev_q <= 1'b0;
        else
            wdt_rst_prev_q <= wdt_reset_req;
    end

    always_comb
    begin
        rst_hit = '0;
        rst_hit[RST_CAUSE_PIN] = rose(rst_pin_prev_q, rst_pin_s2_q);
        rst_hit[RST_CAUSE_WDT] = rose(wdt_rst_prev_q, wdt_reset_req);
        rst_hit[RST_CAUSE_SW] = software_reset_request;
    end

    // A new cause beats a clear landing in the same cycle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rst_flags_q <= '0;
        else
            rst_flags_q <= rst_hit | (rst_flags_q & ~reset_cause_clear);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rst_exc_q <= 1'b0;
        else
            rst_exc_q <= |rst_hit;
    end

    assign reset_exception = rst_exc_q;
    assign reset_cause_flags = rst_flags_q;

    // Non-maskable interrupt sources
    logic wdt_nmi_prev_q;
    logic [NMI_CAUSE_W-1:0] nmi_hit;
    logic [NMI_CAUSE_W-1:0] nmi_flags_q;
    logic nmi_exc_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            wdt_nmi_prev_q <= 1'b0;
        else
            wdt_nmi_prev_q <= wdt_nmi_req;
    end

    always_comb
    begin
        nmi_hit = '0;
        nmi_hit[NMI_CAUSE_PIN] = fell(nmi_pin_prev_q, nmi_pin_s2_q);
        nmi_hit[NMI_CAUSE_WDT] = rose(wdt_nmi_prev_q, wdt_nmi_req);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            nmi_flags_q <= '0;
        else
            nmi_flags_q <= nmi_hit | (nmi_flags_q & ~nmi_cause_clear);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            nmi_exc_q <= 1'b0;
        else
            nmi_exc_q <= |nmi_hit;
    end

    assign nmi_exception = nmi_exc_q;
    assign nmi_cause_flags = nmi_flags_q;

    // System tick timer
    logic tick_zero;
    logic tick_flag_q;
    logic tick_exc_q;

    esf_tick_timer u_tick (
        .mclk(mclk),
        .rstn(rstn),
        .osc_level(osc_s2_q),
        .enable(tick_enable),
        .reload(tick_reload),
        .current(tick_current),
        .zero_event(tick_zero)
    );

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            tick_flag_q <= 1'b0;
        else
            tick_flag_q <= tick_zero | (tick_flag_q & ~tick_flag_clear);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            tick_exc_q <= 1'b0;
        else
            tick_exc_q <= tick_zero;
    end

    assign tick_count_flag = tick_flag_q;
    assign tick_exception = tick_exc_q;
    assign tick_calibration = TICK_CAL_VALUE;

    // Interrupt routing
    logic [NX-1:0] pin_level;
    logic [NI-1:0] src_level;
    logic [NI-1:0] wake_sel;
    logic [NI-1:0] direct_req_q;
    logic [NI-1:0] forced_q;
    logic [NI-1:0] edge_mode;
    logic [NI-1:0] high_act;

    assign pin_level = pin_s2_q | ~pin_input_enable;
    assign src_level = {pin_level, periph_irq};
    assign wake_sel = {pin_wake_sel, periph_wake_sel};

    // Peripherals only support edges on the wake path, so their edge bit is forced
    always_comb
    begin
        edge_mode = '0;
        high_act = '0;
        for (int i = 0; i < NI; i++)
        begin
            edge_mode[i] = wake_active_level[LEVEL_W*i+LEVEL_EDGE_BIT] | (i < NP);
            high_act[i] = wake_active_level[LEVEL_W*i+LEVEL_HIGH_BIT];
        end
    end

    esf_wake_if #(.N(NI)) wk ();

    assign wk.src = src_level & wake_sel;
    assign wk.en = wake_source_enable & wake_sel;
    assign wk.edge_mode = edge_mode;
    assign wk.high_act = high_act;
    assign wk.clr = wake_request_clear;

    esf_wake_detect #(.N(NI)) u_wake (
        .mclk(mclk),
        .rstn(rstn),
        .wk(wk)
    );

    assign wake_request = wk.req;

    // Direct path registered so both routes reach the core from flip-flops
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            direct_req_q <= '0;
        else
            direct_req_q <= src_level & ~wake_sel;
    end

    // Forced pending holds until the core clears it; a set wins over a clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            forced_q <= '0;
        else
            forced_q <= set_pending | (forced_q & ~clear_pending);
    end

    assign core_irq = direct_req_q | wk.req | forced_q;
endmodule : esf_top

// ---- sim/esf_top_asserts.sv ----
// Port-level checker for the exception source front end
`timescale 1ns/1ps
module esf_top_asserts #(
    parameter int NP = 8,
    parameter int NX = 8
)(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic software_reset_request,
    input wire logic wdt_reset_req,
    input wire logic reset_exception,
    input wire logic [esf_pkg::RST_CAUSE_W-1:0] reset_cause_flags,
    input wire logic wdt_nmi_req,
    input wire logic nmi_exception,
    input wire logic [esf_pkg::NMI_CAUSE_W-1:0] nmi_cause_flags,
    input wire logic tick_enable,
    input wire logic [esf_pkg::TICK_W-1:0] tick_reload,
    input wire logic [esf_pkg::TICK_W-1:0] tick_current,
    input wire logic [esf_pkg::TICK_W-1:0] tick_calibration,
    input wire logic tick_count_flag,
    input wire logic tick_exception,
    input wire logic [NP-1:0] periph_wake_sel,
    input wire logic [NP+NX-1:0] wake_request_clear,
    input wire logic [NP+NX-1:0] wake_request,
    input wire logic [NP+NX-1:0] set_pending,
    input wire logic [NP+NX-1:0] clear_pending,
    input wire logic [NP+NX-1:0] core_irq
);
    import esf_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence s_wk_held;
        wake_request[0] && !wake_request_clear[0];
    endsequence
    sequence s_wk_fwd;
        wake_request[0] && core_irq[0];
    endsequence
    property p_sw_rst;
        software_reset_request |=> reset_exception && reset_cause_flags[2];
    endproperty
    a_sw_rst: assert property (p_sw_rst) else $error("sw reset missed");
    property p_wdt_rst;
        $rose(wdt_reset_req) |=> reset_exception && reset_cause_flags[1];
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("wdt reset missed");
    property p_wdt_nmi;
        $rose(wdt_nmi_req) |=> nmi_exception && nmi_cause_flags[1];
    endproperty
    a_wdt_nmi: assert property (p_wdt_nmi) else $error("wdt nmi missed");
    property p_cal;
        tick_calibration == 24'h0009c4;
    endproperty
    a_cal: assert property (p_cal) else $error("calibration wrong");
    property p_tick_exc;
        tick_exception |-> tick_count_flag && tick_current == 24'h000000;
    endproperty
    a_tick_exc: assert property (p_tick_exc) else $error("tick event bad");
    property p_tick_load;
        $rose(tick_enable) |=> tick_current == $past(tick_reload);
    endproperty
    a_tick_load: assert property (p_tick_load) else $error("tick load bad");
    property p_force;
        set_pending[5] |=> core_irq[5] ##1 (core_irq[5] || $past(clear_pending[5]));
    endproperty
    a_force: assert property (p_force) else $error("force lost");
    // Peripheral sources are edge mode, so a held request may only drop on clear
    property p_wk_held;
        s_wk_held |=> s_wk_fwd;
    endproperty
    a_wk_held: assert property (p_wk_held) else $error("wake dropped");
endmodule : esf_top_asserts
bind esf_top esf_top_asserts #(.NP(NP), .NX(NX)) u_asserts (.mclk, .rstn,
    .software_reset_request, .wdt_reset_req, .reset_exception, .reset_cause_flags,
    .wdt_nmi_req, .nmi_exception, .nmi_cause_flags, .tick_enable, .tick_reload,
    .tick_current, .tick_calibration, .tick_count_flag, .tick_exception,
    .periph_wake_sel, .wake_request_clear, .wake_request, .set_pending, .clear_pending,
    .core_irq);

// ---- sim/esf_core_model.sv ----
// Far-side model: free-running oscillator and core tick event counter
`timescale 1ns/1ps
module esf_core_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic tick_exception,
    output logic main_oscillator_input,
    output int tick_hits
);
    // Period of eight mclk cycles keeps the synchroniser well within its limit
    initial
    begin
        main_oscillator_input = 1'b0;
        #3;
        forever #40 main_oscillator_input = ~main_oscillator_input;
    end
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            tick_hits <= 0;
        else if (tick_exception)
            tick_hits <= tick_hits + 1;
    end
endmodule : esf_core_model

// ---- sim/esf_top_tb.sv ----
// Self-checking bench for the exception source front end
`timescale 1ns/1ps
module esf_top_tb;
    import esf_pkg::*;
    localparam int NP = 8;
    localparam int NX = 8;
    localparam int NS = NP + NX;
    logic mclk, rstn, reset_pin, wdt_reset_req, software_reset_request, reset_exception;
    logic nmi_pin_n, wdt_nmi_req, nmi_exception, main_oscillator_input, tick_enable;
    logic tick_flag_clear, tick_count_flag, tick_exception;
    logic [2:0] reset_cause_clear, reset_cause_flags;
    logic [1:0] nmi_cause_clear, nmi_cause_flags;
    logic [TICK_W-1:0] tick_reload, tick_current, tick_calibration;
    logic [NP-1:0] periph_irq, periph_wake_sel;
    logic [NX-1:0] ext_irq_pin, pin_input_enable, pin_wake_sel;
    logic [NS-1:0] wake_source_enable, wake_request_clear, wake_request;
    logic [NS-1:0] set_pending, clear_pending, core_irq;
    logic [2*NS-1:0] wake_active_level;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int tick_hits;
    time t0;
    esf_top #(.NP(NP), .NX(NX)) u_dut (.mclk, .rstn, .reset_pin, .wdt_reset_req,
        .software_reset_request, .reset_cause_clear, .reset_exception, .reset_cause_flags,
        .nmi_pin_n, .wdt_nmi_req, .nmi_cause_clear, .nmi_exception, .nmi_cause_flags,
        .main_oscillator_input, .tick_enable, .tick_reload, .tick_flag_clear, .tick_current,
        .tick_calibration, .tick_count_flag, .tick_exception, .periph_irq, .periph_wake_sel,
        .ext_irq_pin, .pin_input_enable, .pin_wake_sel, .wake_source_enable,
        .wake_active_level, .wake_request_clear, .wake_request, .set_pending,
        .clear_pending, .core_irq);
    esf_core_model u_model (.mclk, .rstn, .tick_exception, .main_oscillator_input,
        .tick_hits);
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask : cyc
    function automatic logic watched(input int sel);
        case (sel)
            0: watched = reset_exception;
            1: watched = nmi_exception;
            default: watched = tick_exception;
        endcase
    endfunction : watched
    // Bounded wait so a missing event cannot hang the run
    task automatic wait_for(input int sel, input int lim);
        int k;
        k = 0;
        while (watched(sel) !== 1'b1 && k < lim)
        begin
            @(negedge mclk);
            k++;
        end
    endtask : wait_for
    task wrap_up;
        $display("TB: counts fail_count=%0d checked=%0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    initial
    begin
        {rstn, reset_pin, wdt_reset_req, software_reset_request, wdt_nmi_req} = '0;
        {tick_enable, tick_flag_clear, reset_cause_clear, nmi_cause_clear} = '0;
        {periph_irq, periph_wake_sel, ext_irq_pin, pin_wake_sel} = '0;
        {wake_source_enable, wake_active_level, wake_request_clear} = '0;
        {set_pending, clear_pending} = '0;
        nmi_pin_n = 1'b1;
        pin_input_enable = '1;
        tick_reload = 24'h000002;
        cyc(3);
        rstn = 1'b1;
        cyc(1);
        chk(reset_cause_flags, 3'h0);
        chk(tick_calibration, 24'h0009c4);
        software_reset_request = 1'b1;
        cyc(1);
        software_reset_request = 1'b0;
        chk(reset_exception, 1'b1);
        cyc(1);
        chk(reset_cause_flags, 3'h4);
        reset_cause_clear = 3'h4;
        cyc(1);
        reset_cause_clear = 3'h0;
        chk(reset_cause_flags, 3'h0);
        reset_pin = 1'b1;
        wait_for(0, 8);
        chk(reset_exception, 1'b1);
        wdt_reset_req = 1'b1;
        cyc(1);
        chk(reset_exception, 1'b1);
        chk(reset_cause_flags, 3'h3);
        nmi_pin_n = 1'b0;
        wait_for(1, 8);
        chk(nmi_cause_flags, 2'h1);
        wdt_nmi_req = 1'b1;
        cyc(1);
        chk(nmi_cause_flags, 2'h3);
        nmi_cause_clear = 2'h1;
        cyc(1);
        nmi_cause_clear = 2'h0;
        chk(nmi_cause_flags, 2'h2);
        tick_enable = 1'b1;
        cyc(1);
        chk(tick_current, 24'h000002);
        wait_for(2, 2000);
        chk(tick_count_flag, 1'b1);
        t0 = $time;
        cyc(1);
        wait_for(2, 2000);
        chk(32'(($time - t0) / 10), 32'((tick_reload + 1) * TICK_DIV * 8));
        tick_enable = 1'b0;
        tick_flag_clear = 1'b1;
        cyc(1);
        tick_flag_clear = 1'b0;
        cyc(1);
        chk(tick_count_flag, 1'b0);
        chk(tick_hits, 2);
        periph_irq[1] = 1'b1;
        cyc(1);
        chk(core_irq[1], 1'b1);
        periph_irq[1] = 1'b0;
        pin_input_enable[2] = 1'b0;
        cyc(4);
        chk(core_irq[1], 1'b0);
        chk(core_irq[NP+2], 1'b1);
        pin_input_enable[2] = 1'b1;
        ext_irq_pin[3] = 1'b1;
        cyc(4);
        chk(core_irq[NP+3:NP+2], 2'h2);
        set_pending[5] = 1'b1;
        cyc(1);
        set_pending[5] = 1'b0;
        chk(core_irq[5], 1'b1);
        cyc(1);
        clear_pending[5] = 1'b1;
        cyc(1);
        clear_pending[5] = 1'b0;
        cyc(1);
        chk(core_irq[5], 1'b0);
        periph_wake_sel[0] = 1'b1;
        wake_source_enable[0] = 1'b1;
        wake_active_level[1:0] = 2'h3;
        cyc(1);
        periph_irq[0] = 1'b1;
        cyc(1);
        chk(wake_request[0], 1'b1);
        periph_irq[0] = 1'b0;
        cyc(3);
        chk(core_irq[0], 1'b1);
        wake_request_clear[0] = 1'b1;
        cyc(1);
        wake_request_clear[0] = 1'b0;
        cyc(1);
        chk(wake_request[0], 1'b0);
        pin_wake_sel[1] = 1'b1;
        wake_source_enable[NP+1] = 1'b1;
        wake_active_level[2*(NP+1)+:2] = 2'h1;
        ext_irq_pin[1] = 1'b1;
        cyc(4);
        chk(core_irq[NP+1], 1'b1);
        ext_irq_pin[1] = 1'b0;
        cyc(4);
        chk(wake_request[NP+1], 1'b0);
        wake_source_enable[NP+1] = 1'b0;
        ext_irq_pin[1] = 1'b1;
        cyc(4);
        chk(wake_request[NP+1], 1'b0);
        pin_wake_sel[5:4] = 2'h3;
        wake_source_enable[NP+4+:2] = 2'h3;
        wake_active_level[2*(NP+4)+:4] = 4'h2;
        cyc(2);
        chk(core_irq[NP+5], 1'b1);
        ext_irq_pin[5:4] = 2'h3;
        cyc(4);
        chk(wake_request[NP+5:NP+4], 2'h0);
        ext_irq_pin[4] = 1'b0;
        cyc(4);
        chk(wake_request[NP+5:NP+4], 2'h1);
        ext_irq_pin[4] = 1'b1;
        cyc(4);
        chk(core_irq[NP+4], 1'b1);
        wake_request_clear[NP+4] = 1'b1;
        cyc(1);
        wake_request_clear[NP+4] = 1'b0;
        chk(wake_request[NP+4], 1'b0);
        wrap_up();
    end
endmodule : esf_top_tb
